//--- dv/mad_decode_properties.sv
// Concurrent checks on the address map decode ports
`timescale 1ns/10ps
module mad_decode_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Program side
    input wire logic pc_advance,
    input wire logic pc_backward,
    input wire logic pc_load,
    input wire logic [22:0] pc_load_target,
    input wire logic [22:0] pc_q,
    input wire logic tbl_req,
    input wire logic [15:0] tbl_offset,
    input wire logic [7:0] table_page_select,
    input wire logic [23:0] prog_addr,
    input wire logic prog_in_vector,
    input wire logic tbl_valid_q,
    input wire logic tbl_denied_q,
    // Data side
    input wire mad_pkg::mad_dreq_type rd_dreq,
    input wire logic rd_valid_q,
    input wire logic [15:0] rd_data_q,
    input wire mad_pkg::mad_dreq_type wr_dreq,
    input wire logic sfr_wr_q,
    input wire logic [1:0] sfr_wr_be_q,
    input wire logic addr_error_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic lane_q;

    // Byte lane of the last write request
    always_ff @(posedge clk) lane_q <= wr_dreq.ea[0];

    // ====================
    // Program side
    chk_pc_step: assert property (
        pc_advance && !pc_load |=> pc_q == ($past(pc_backward) ?
        $past(pc_q) - 23'h2 : $past(pc_q) + 23'h2)) else $error("pc step wrong");
    chk_pc_load: assert property (
        pc_load |=> pc_q == ($past(pc_load_target) & 23'h7ffffe)) else $error("pc load wrong");
    chk_prog_addr: assert property (
        prog_addr == (tbl_req ? {table_page_select, tbl_offset[15:1], 1'b0} : {1'b0, pc_q}))
        else $error("program address wrong");
    chk_vector_flag: assert property (
        prog_in_vector == (prog_addr <= 24'h000200)) else $error("vector flag wrong");
    chk_tbl_grant: assert property (
        tbl_req |=> tbl_valid_q && !tbl_denied_q) else $error("table answer wrong");

    // ====================
    // Data side
    chk_rd_trap: assert property (
        rd_dreq.req && !rd_dreq.byte_op && rd_dreq.ea[0] |=> rd_valid_q && addr_error_q)
        else $error("read trap missing");
    chk_wr_drop: assert property (
        wr_dreq.req && !wr_dreq.byte_op && wr_dreq.ea[0] |=> addr_error_q && !sfr_wr_q)
        else $error("misaligned write not dropped");
    chk_rd_outside: assert property (
        rd_dreq.req && rd_dreq.ea[15] && rd_dreq.page[8:1] != 8'h00 |=>
        rd_valid_q && rd_data_q == 16'h0000) else $error("outside read not zero");
    chk_byte_lane: assert property (
        wr_dreq.req && wr_dreq.byte_op && wr_dreq.ea < 16'h1000 |=>
        sfr_wr_q && sfr_wr_be_q == {lane_q, !lane_q}) else $error("byte lane wrong");
    chk_wr_outside: assert property (
        wr_dreq.req && wr_dreq.ea[15] && wr_dreq.page[8:1] != 8'h00 |=> !sfr_wr_q)
        else $error("outside write not dropped");

    // Main scenarios
    cover property (tbl_req && tbl_offset[0]);
    cover property (wr_dreq.req && wr_dreq.byte_op);
    cover property (rd_dreq.req && rd_dreq.ea[15]);
endmodule

bind mad_decode mad_decode_chk i_chk (.clk, .reset, .pc_advance, .pc_backward, .pc_load,
    .pc_load_target, .pc_q, .tbl_req, .tbl_offset, .table_page_select, .prog_addr,
    .prog_in_vector, .tbl_valid_q, .tbl_denied_q, .rd_dreq, .rd_valid_q, .rd_data_q,
    .wr_dreq, .sfr_wr_q, .sfr_wr_be_q, .addr_error_q);

//--- dv/mad_far_model.sv
// Far side model: program memory and peripheral register responders
`timescale 1ns/10ps
module mad_far_model (
    // Program memory port
    input wire logic [23:0] prog_addr,
    output logic [23:0] prog_rd_word,
    // Register space read port
    input wire logic [11:0] sfr_rd_addr,
    output logic sfr_rd_claim,
    output logic [15:0] sfr_rd_data
);
    // Jump at the reset vector, start address next, else an address pattern
    assign prog_rd_word = prog_addr == 24'h000000 ? 24'h040000 :
        prog_addr == 24'h000002 ? 24'h000100 : {prog_addr[7:0] ^ 8'h3c, prog_addr[15:0]};
    // Lower half of register space is owned by peripherals
    assign sfr_rd_claim = !sfr_rd_addr[11];
    assign sfr_rd_data = sfr_rd_claim ? {4'h5, sfr_rd_addr} : 16'h0000;
endmodule

//--- dv/testbench.sv
// Random self-checking bench for the address map decode
`timescale 1ns/10ps
module testbench;
    // ====================
    // Signals and model state
    logic clk = 0, reset = 1, pc_advance = 0, pc_backward = 0, pc_load = 0, tbl_req = 0;
    logic [22:0] pc_load_target = '0, pc_q, e_pc = '0;
    logic [15:0] tbl_offset = '0, wr_data = '0, tbl_data_q, rd_data_q, sfr_rd_data;
    logic [15:0] sfr_wr_data_q, e_td, e_sd, e_sm;
    logic [7:0] table_page_select = '0;
    logic [23:0] prog_addr, prog_rd_word, pa, x;
    logic [11:0] sfr_rd_addr, sfr_wr_addr_q, e_sa;
    logic [16:0] e_rd = '0;
    logic [3:0] e_fl = '0;
    logic [1:0] sfr_wr_be_q, e_be;
    logic prog_in_vector, tbl_valid_q, tbl_denied_q, rd_valid_q, sfr_rd_claim, sfr_wr_q;
    logic addr_error_q, bad, hold, mon = 0;
    mad_pkg::mad_dreq_type rd_dreq = '0, wr_dreq = '0;
    integer seed = 33267, error_cnt = 0, n_compared = 0, i, a, k;
    logic [7:0] ramb [int];

    always #2.5 clk = ~clk;
    mad_decode i_dut (.*);
    mad_far_model i_far (.*);

    // Extended address after paging
    function automatic logic [23:0] ext(input mad_pkg::mad_dreq_type q);
        return q.ea[15] ? {q.page, q.ea[14:0]} : {8'h00, q.ea};
    endfunction

    // Expected read data, bit 16 marks a known value
    function automatic logic [16:0] rd_exp(input logic [23:0] y, input logic bo);
        logic [15:0] v;
        int w;
        w = int'({y[23:1], 1'b0});
        if (y > 24'h00cfff)
            return 17'h10000;
        if (y > 24'h000fff) begin
            if (bo)
                return ramb.exists(int'(y)) ? {9'h100, ramb[int'(y)]} : 17'h0;
            return ramb.exists(w) && ramb.exists(w + 1) ? {1'b1, ramb[w + 1], ramb[w]} : 17'h0;
        end
        v = y[11] ? 16'h0000 : {4'h5, y[11:1], 1'b0};
        return bo ? {9'h100, y[0] ? v[15:8] : v[7:0]} : {1'b1, v};
    endfunction

    // Random data request over register, RAM and paged regions
    function automatic mad_pkg::mad_dreq_type mk(input logic [31:0] r, input logic off);
        mk = '0;
        mk.req = r[31] && !off;
        mk.byte_op = r[30];
        mk.ea = {r[15], 2'b00, r[12:11], 5'b0, r[5:0]};
        mk.page = {7'h0, r[17:16]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Compare last cycle's results, then predict the next ones
    always @(posedge clk) begin
        pa = tbl_req ? {table_page_select, tbl_offset[15:1], 1'b0} : {1'b0, e_pc};
        if (mon) begin
            check(pc_q, e_pc);
            check(prog_addr, pa);
            check(prog_in_vector, pa <= 24'h000200);
            check(tbl_denied_q, 1'b0);
            check({tbl_valid_q, rd_valid_q, addr_error_q, sfr_wr_q}, e_fl);
            if (e_fl[3]) check(tbl_data_q, e_td);
            if (e_fl[2] && e_rd[16]) check(rd_data_q, e_rd[15:0]);
            if (e_fl[0]) check({sfr_wr_addr_q[11:1], sfr_wr_be_q, sfr_wr_data_q & e_sm},
                {e_sa[11:1], e_be, e_sd & e_sm});
        end
        e_fl = '0;
        if (reset)
            e_pc = '0;
        else begin
            if (pc_load)
                e_pc = pc_load_target & 23'h7ffffe;
            else if (pc_advance)
                e_pc = pc_backward ? e_pc - 23'h2 : e_pc + 23'h2;
            e_td = tbl_offset[0] ? {8'h00, prog_rd_word[23:16]} : prog_rd_word[15:0];
            e_rd = rd_exp(ext(rd_dreq), rd_dreq.byte_op);
            x = ext(wr_dreq);
            bad = !wr_dreq.byte_op && wr_dreq.ea[0];
            e_fl = {tbl_req, rd_dreq.req, rd_dreq.req && !rd_dreq.byte_op && rd_dreq.ea[0]
                || wr_dreq.req && bad, wr_dreq.req && !bad && x < 24'h001000};
            e_sa = x[11:0];
            e_be = wr_dreq.byte_op ? {x[0], !x[0]} : 2'b11;
            e_sd = wr_dreq.byte_op ? {2{wr_data[7:0]}} : wr_data;
            e_sm = {{8{e_be[1]}}, {8{e_be[0]}}};
            k = int'(x);
            if (wr_dreq.req && !bad && x >= 24'h001000 && x <= 24'h00cfff) begin
                ramb[k] = wr_data[7:0];
                if (!wr_dreq.byte_op)
                    ramb[k + 1] = wr_data[15:8];
            end
        end
    end

    // Reset, then random traffic with one reset in mid-run
    initial begin
        repeat (2) @(posedge clk);
        mon <= 1;
        repeat (14) @(posedge clk);
        for (i = 0; i < 4000; i++) begin
            hold = i > 2000 && i < 2003;
            reset <= hold;
            a = $random(seed);
            {pc_advance, pc_backward, tbl_req} <= a[2:0];
            pc_load <= a[5:3] == 3'b000;
            pc_load_target <= $random(seed) & 23'h0003ff;
            tbl_offset <= $random(seed);
            table_page_select <= a[15:8];
            rd_dreq <= mk($random(seed), hold);
            wr_dreq <= mk($random(seed), hold);
            wr_data <= $random(seed);
            @(posedge clk);
        end
        complete_run();
    end

    // Watchdog against a hang
    initial begin
        #40000;
        error_cnt++;
        complete_run();
    end
endmodule

//--- src/mad_decode.sv
// Program and data address map decode for the 16-bit controller core
`timescale 1ns/10ps
`include "mad_params.svh"

module mad_decode (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Program counter control from the fetch unit
    input wire logic pc_advance,
    input wire logic pc_backward,
    input wire logic pc_load,
    input wire logic [22:0] pc_load_target,
    output logic [22:0] pc_q,
    // Table read request
    input wire logic tbl_req,
    input wire logic [15:0] tbl_offset,
    input wire logic [7:0] table_page_select,
    // Program memory port
    output logic [23:0] prog_addr,
    output logic prog_in_vector,
    input wire logic [23:0] prog_rd_word,
    // Table read answer
    output logic tbl_valid_q,
    output logic [15:0] tbl_data_q,
    output logic tbl_denied_q,
    // Data read generator
    input wire mad_pkg::mad_dreq_type rd_dreq,
    output logic rd_valid_q,
    output logic [15:0] rd_data_q,
    // Data write generator
    input wire mad_pkg::mad_dreq_type wr_dreq,
    input wire logic [15:0] wr_data,
    // Register space port toward peripherals
    output logic [11:0] sfr_rd_addr,
    input wire logic sfr_rd_claim,
    input wire logic [15:0] sfr_rd_data,
    output logic sfr_wr_q,
    output logic [11:0] sfr_wr_addr_q,
    output logic [1:0] sfr_wr_be_q,
    output logic [15:0] sfr_wr_data_q,
    // Address error trap
    output logic addr_error_q
);

    // =====================================================
    // Program counter
    logic [22:0] pc_d;
    wire [22:0] pc_step_val;

    // The counter wraps modulo 2^23; being 23 bits wide, fetch can
    // never address the upper half of program space
    // Step by two so the counter never leaves the lower word
    assign pc_step_val = pc_backward ? (pc_q - `MAD_PC_STEP) : (pc_q + `MAD_PC_STEP);

    // Load forces even alignment, advance steps by two
    always_comb begin
        pc_d = pc_q;
        if (pc_load) begin
            pc_d = {pc_load_target[22:1], 1'b0};
        end else if (pc_advance) begin
            pc_d = pc_step_val;
        end
    end

    // Counter register, zero after reset so the reset jump runs first
    always_ff @(posedge clk) begin
        if (reset) begin
            pc_q <= `MAD_PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    // =====================================================
    // Program address selection
    wire [23:0] tbl_addr;
    wire tbl_upper_half;
    wire tbl_allowed;
    wire tbl_upper_word;

    // Table page over offset forms the 24-bit address
    assign tbl_addr = {table_page_select, tbl_offset};
    assign tbl_upper_half = (tbl_addr > `MAD_USER_TOP);
    // Page bit 7 is also address bit 23, so the check keeps the rule
    // explicit should the page ever be widened
    // Upper half only for identification reads with the page bit set
    assign tbl_allowed = !tbl_upper_half ||
                         table_page_select[`MAD_TPS_ID_BIT];
    // Odd address picks the upper word of the location
    assign tbl_upper_word = tbl_offset[0];

    wire [23:0] fetch_addr;
    wire [23:0] tbl_word_addr;

    // Fetch uses the zero-extended counter, lower word only
    assign fetch_addr = {1'b0, pc_q};
    // Table reads fetch the whole location at its even address
    assign tbl_word_addr = {tbl_addr[23:1], 1'b0};
    // A table read borrows the program port for its cycle
    assign prog_addr = tbl_req ? tbl_word_addr : fetch_addr;
    assign prog_in_vector = (prog_addr <= `MAD_VECTOR_LAST);

    // =====================================================
    // Table read answer
    wire [15:0] tbl_word;

    // Upper word carries bits 23:16 with its top byte unimplemented
    assign tbl_word = tbl_upper_word ? {8'h00, prog_rd_word[23:16]} :
                      prog_rd_word[15:0];

    // The program port answers in the request cycle, so the word is
    // taken at the request edge and never waits on the next fetch
    // Result one cycle after the request; denied reads give zero
    always_ff @(posedge clk) begin
        if (reset) begin
            tbl_valid_q <= 1'b0;
            tbl_data_q <= 16'h0000;
            tbl_denied_q <= 1'b0;
        end else begin
            tbl_valid_q <= tbl_req;
            tbl_data_q <= (tbl_req && tbl_allowed) ? tbl_word : 16'h0000;
            tbl_denied_q <= tbl_req && !tbl_allowed;
        end
    end

    // =====================================================
    // Address resolution, one resolver per generator
    mad_pkg::mad_resolved_type rd_res;
    mad_pkg::mad_resolved_type wr_res;

    // Two resolvers so a read and a write resolve in the same cycle
    // Read generator path
    mad_ea_resolve u_rd_resolve (
        .dreq(rd_dreq),
        .res(rd_res)
    );

    // Write generator path
    mad_ea_resolve u_wr_resolve (
        .dreq(wr_dreq),
        .res(wr_res)
    );

    // =====================================================
    // Data RAM, two byte-wide halves with shared word decode
    // Contents are not reset; a word read before any write is unknown
    logic [7:0] ram_lo [0:`MAD_RAM_WORDS-1];
    logic [7:0] ram_hi [0:`MAD_RAM_WORDS-1];

    // Word index relative to the start of RAM
    function automatic logic [14:0] ram_index(input logic [23:0] ext);
        logic [23:0] rel;
        rel = ext - `MAD_RAM_FIRST;
        return rel[15:1];
    endfunction

    // Region match, shared by the read and the write path
    function automatic logic region_is(input mad_pkg::mad_resolved_type r,
                                       input mad_pkg::mad_region_type want);
        return r.region == want;
    endfunction

    wire [14:0] rd_idx;
    wire [14:0] wr_idx;
    assign rd_idx = ram_index(rd_res.ext);
    assign wr_idx = ram_index(wr_res.ext);

    // =====================================================
    // Write decode
    wire wr_ok;
    wire wr_to_ram;
    wire wr_to_sfr;
    wire [1:0] wr_be;
    wire [15:0] wr_lanes;

    // Misaligned word writes execute without storing
    assign wr_ok = wr_dreq.req && !wr_res.misaligned;
    // Anything outside the implemented area goes nowhere
    assign wr_to_ram = wr_ok && region_is(wr_res, mad_pkg::MAD_REG_RAM);
    assign wr_to_sfr = wr_ok && region_is(wr_res, mad_pkg::MAD_REG_SFR);

    // Byte write enables only the lane chosen by address bit 0
    assign wr_be = !wr_dreq.byte_op ? 2'h3 :
                   (wr_dreq.ea[0] ? 2'h2 : 2'h1);
    // Copying to both lanes lets a peripheral ignore the address bit
    // Byte data arrives in the low byte and is copied to both lanes
    assign wr_lanes = wr_dreq.byte_op ? {wr_data[7:0], wr_data[7:0]} : wr_data;

    // Low lane at the even address, high lane at the odd
    always_ff @(posedge clk) begin
        if (wr_to_ram && wr_be[0]) begin
            ram_lo[wr_idx] <= wr_lanes[7:0];
        end
    end

    // High lane written independently
    always_ff @(posedge clk) begin
        if (wr_to_ram && wr_be[1]) begin
            ram_hi[wr_idx] <= wr_lanes[15:8];
        end
    end

    wire [11:0] wr_sfr_addr;

    // Peripherals decode whole words; the byte enables pick the lane
    assign wr_sfr_addr = {wr_res.ext[11:1], 1'b0};

    // Register space write strobe toward the peripherals
    always_ff @(posedge clk) begin
        if (reset) begin
            sfr_wr_q <= 1'b0;
            sfr_wr_addr_q <= 12'h000;
            sfr_wr_be_q <= 2'h0;
            sfr_wr_data_q <= 16'h0000;
        end else begin
            sfr_wr_q <= wr_to_sfr;
            sfr_wr_addr_q <= wr_sfr_addr;
            sfr_wr_be_q <= wr_to_sfr ? wr_be : 2'h0;
            sfr_wr_data_q <= wr_lanes;
        end
    end

    // =====================================================
    // Read decode
    wire rd_ram;
    wire rd_sfr;
    wire [15:0] rd_ram_word;
    wire [15:0] rd_sfr_word;
    wire [15:0] rd_word;
    wire [7:0] rd_byte_sel;
    wire [15:0] rd_result;

    // Register port sees the word address of the access
    assign sfr_rd_addr = {rd_res.ext[11:1], 1'b0};
    // Region of the read decides which source answers
    assign rd_ram = region_is(rd_res, mad_pkg::MAD_REG_RAM);
    assign rd_sfr = region_is(rd_res, mad_pkg::MAD_REG_SFR);

    // A write to the same word in this cycle lands at the edge, so the
    // read still returns the old contents
    // Whole word is read; misaligned reads use the word below
    assign rd_ram_word = {ram_hi[rd_idx], ram_lo[rd_idx]};
    // Register addresses nobody claims read as zero
    assign rd_sfr_word = sfr_rd_claim ? sfr_rd_data : 16'h0000;
    // Outside the implemented area the word is zero
    assign rd_word = rd_ram ? rd_ram_word :
                     (rd_sfr ? rd_sfr_word : 16'h0000);

    // Byte reads take the lane by address bit 0 into the low byte
    assign rd_byte_sel = rd_dreq.ea[0] ? rd_word[15:8] : rd_word[7:0];
    assign rd_result = rd_dreq.byte_op ? {8'h00, rd_byte_sel} : rd_word;

    // Read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 16'h0000;
        end else begin
            rd_valid_q <= rd_dreq.req;
            rd_data_q <= rd_dreq.req ? rd_result : 16'h0000;
        end
    end

    // =====================================================
    // Address error trap
    wire rd_trap;
    wire wr_trap;
    wire trap_d;

    // Read side: a word access on an odd byte still returns data
    assign rd_trap = rd_dreq.req && rd_res.misaligned;
    // Write side: the store is already held back in the write decode
    assign wr_trap = wr_dreq.req && wr_res.misaligned;
    // A read and a write trap in one cycle raise a single pulse
    assign trap_d = rd_trap || wr_trap;

    // One-cycle trap pulse aligned with the read answer
    always_ff @(posedge clk) begin
        if (reset) begin
            addr_error_q <= 1'b0;
        end else begin
            addr_error_q <= trap_d;
        end
    end

endmodule

//--- src/mad_ea_resolve.sv
// Effective address to extended data address resolver
`timescale 1ns/10ps
`include "mad_params.svh"

module mad_ea_resolve (
    // Request in
    input mad_pkg::mad_dreq_type dreq,
    // Resolved address out
    output mad_pkg::mad_resolved_type res
);

    wire paged;
    wire [23:0] ext;
    wire in_sfr;
    wire in_ram;

    // =====================================================
    // Paging
    // Upper half of the base range is a window into the paged space
    assign paged = dreq.ea[`MAD_EA_PAGED_BIT];
    assign ext = paged ? {dreq.page, dreq.ea[14:0]} : {8'h00, dreq.ea};

    // =====================================================
    // Region decode
    assign in_sfr = (ext <= `MAD_SFR_LAST);
    assign in_ram = (ext >= `MAD_RAM_FIRST) && (ext <= `MAD_RAM_LAST);

    // Pack the result; word access on an odd byte is misaligned
    assign res.ext = ext;
    assign res.region = in_sfr ? mad_pkg::MAD_REG_SFR :
                        (in_ram ? mad_pkg::MAD_REG_RAM : mad_pkg::MAD_REG_NONE);
    assign res.misaligned = !dreq.byte_op && dreq.ea[0];

endmodule

//--- src/mad_params.svh
// Constants of the program and data address map decode
`ifndef MAD_PARAMS_SVH
`define MAD_PARAMS_SVH

// =====================================================
// Program space
`define MAD_PROG_AW 24
`define MAD_PC_W 23
`define MAD_PC_RESET 23'h000000
`define MAD_PC_STEP 23'h000002
`define MAD_USER_TOP 24'h7fffff
`define MAD_VECTOR_LAST 24'h000200
`define MAD_TPS_W 8
`define MAD_TPS_ID_BIT 7

// =====================================================
// Data space
`define MAD_EA_W 16
`define MAD_PAGE_W 9
`define MAD_EXT_W 24
`define MAD_SFR_LAST 24'h000fff
`define MAD_RAM_FIRST 24'h001000
`define MAD_RAM_LAST 24'h00cfff
`define MAD_RAM_WORDS 24576
`define MAD_RAM_IDX_W 15
`define MAD_EA_PAGED_BIT 15

`endif

//--- src/mad_pkg.sv
// Types shared by the address map decode files
package mad_pkg;

    // Region that a resolved data address falls in
    typedef enum logic [1:0] {
        MAD_REG_SFR,
        MAD_REG_RAM,
        MAD_REG_NONE
    } mad_region_type;

    // One data access request from an address generator
    typedef struct packed {
        logic req;
        logic byte_op;
        logic [15:0] ea;
        logic [8:0] page;
    } mad_dreq_type;

    // A data address after paging and decode
    typedef struct packed {
        logic [23:0] ext;
        mad_region_type region;
        logic misaligned;
    } mad_resolved_type;

endpackage
